// >>> rtl/nva_device.sv
// device end: pointer bank, control register, array, write timer, interrupt
//
// Contract
// - power-on clears the write permit bit
// - power-on zeroes both pointer pairs
// - write completion raises interrupt request
// - interrupt needs own, group and global enables
// - write end sets both request flags
// - service clears only the group flag
// - software clears the nonvolatile flag itself
// - write start follows write permit immediately
// - global enable off around write start
// - keep write permit cleared when idle
// - keep pointer high bytes at zero
// - read sequence through indirect port one
// - write sequence through indirect port one
// - optional read back after write
// - read start needs permit; auto clears
// - write start needs write permit
// - write start clears at timer end
// - data register holds until next operation
`timescale 1ns/1ps
module nva_device #(
  parameter int WRITE_CYCLES = nva_pkg::NVA_WRITE_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic rstn,
  nva_if.device     bus
);
  import nva_pkg::*;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]            array_mem [NVA_DEPTH];
  logic [NVA_ADDR_W-1:0] nv_address_reg_ff, nxt_nv_address_reg;
  logic [7:0]            nv_data_reg_ff, nxt_nv_data_reg;
  logic [7:0]            pointer_one_low_ff, nxt_pointer_one_low;
  logic [7:0]            pointer_one_high_ff, nxt_pointer_one_high;
  logic [7:0]            pointer_two_low_ff, nxt_pointer_two_low;
  logic [7:0]            pointer_two_high_ff, nxt_pointer_two_high;
  logic                  write_permit_ff, nxt_write_permit;
  logic                  read_permit_ff, nxt_read_permit;
  logic                  wr_start_ff, nxt_wr_start;
  logic                  rd_start_ff, nxt_rd_start;
  logic                  nv_irq_enable_ff, nxt_nv_irq_enable;
  logic                  mf_irq_enable_ff, nxt_mf_irq_enable;
  logic                  global_irq_enable_ff, nxt_global_irq_enable;
  logic                  nv_irq_flag_ff, nxt_nv_irq_flag;
  logic                  mf_irq_flag_ff, nxt_mf_irq_flag;
  logic [7:0]            rdata_ff, nxt_rdata;
  logic                  rvalid_ff, nxt_rvalid;
  logic                  irq_ff, nxt_irq;
  logic [1:0]            rd_cnt_ff, nxt_rd_cnt;
  // write timer and its completion crossing
  logic [15:0]           tmr_cnt_ff, nxt_tmr_cnt;
  logic                  tmr_busy_ff, nxt_tmr_busy;
  logic                  tmr_done_tgl_ff, nxt_tmr_done_tgl;
  logic                  done_sync1_ff, done_sync2_ff, done_seen_ff;
  logic                  wr_done;
  logic                  ctrl_sel;
  logic                  mem_we;
  logic [3:0]            ctrl_view;

  // ---------------------------------------------------------------
  // control register decode
  // ---------------------------------------------------------------
  function automatic logic ptr_is_ctrl(input logic [7:0] lo, input logic [7:0] hi);
    ptr_is_ctrl = (lo == NVA_CTRL_LOW) && (hi == NVA_CTRL_HIGH);
  endfunction

  assign ctrl_sel  = ptr_is_ctrl(pointer_one_low_ff, pointer_one_high_ff);
  assign wr_done   = done_sync2_ff ^ done_seen_ff;
  assign ctrl_view = {write_permit_ff, wr_start_ff, read_permit_ff, rd_start_ff};

  // ---------------------------------------------------------------
  // register next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_nv_address_reg    = nv_address_reg_ff;
    nxt_nv_data_reg       = nv_data_reg_ff;
    nxt_pointer_one_low   = pointer_one_low_ff;
    nxt_pointer_one_high  = pointer_one_high_ff;
    nxt_pointer_two_low   = pointer_two_low_ff;
    nxt_pointer_two_high  = pointer_two_high_ff;
    nxt_write_permit      = write_permit_ff;
    nxt_read_permit       = read_permit_ff;
    nxt_wr_start          = wr_start_ff;
    nxt_rd_start          = rd_start_ff;
    nxt_nv_irq_enable     = nv_irq_enable_ff;
    nxt_mf_irq_enable     = mf_irq_enable_ff;
    nxt_global_irq_enable = global_irq_enable_ff;
    nxt_nv_irq_flag       = nv_irq_flag_ff;
    nxt_mf_irq_flag       = mf_irq_flag_ff;
    nxt_rdata             = rdata_ff;
    nxt_rvalid            = 1'b0;
    nxt_rd_cnt            = rd_cnt_ff;
    mem_we                = 1'b0;

    if (bus.op == NVA_OP_WRITE) begin
      case (bus.sel)
        NVA_SEL_ADDR:  nxt_nv_address_reg   = bus.wdata[NVA_ADDR_W-1:0];
        NVA_SEL_DATA:  nxt_nv_data_reg      = bus.wdata;
        NVA_SEL_PTR1L: nxt_pointer_one_low  = bus.wdata;
        NVA_SEL_PTR1H: nxt_pointer_one_high = bus.wdata;
        NVA_SEL_PTR2L: nxt_pointer_two_low  = bus.wdata;
        NVA_SEL_PTR2H: nxt_pointer_two_high = bus.wdata;
        NVA_SEL_IND1: begin
          if (ctrl_sel) begin
            nxt_write_permit = bus.wdata[NVA_BIT_WR_PERMIT];
            nxt_read_permit  = bus.wdata[NVA_BIT_RD_PERMIT];
            // starts are never cleared by software; the same write cannot
            // set both, and one may not start while the other runs
            if (bus.wdata[NVA_BIT_WR_START] && write_permit_ff && !bus.wdata[NVA_BIT_RD_START]
                && !rd_start_ff && !wr_start_ff) begin
              nxt_wr_start = 1'b1;
              mem_we       = 1'b1;
            end
            if (bus.wdata[NVA_BIT_RD_START] && read_permit_ff && !bus.wdata[NVA_BIT_WR_START]
                && !rd_start_ff && !wr_start_ff) begin
              nxt_rd_start = 1'b1;
              nxt_rd_cnt   = 2'(NVA_READ_CYCLES - 1);
            end
          end
        end
        NVA_SEL_IRQ: begin
          nxt_nv_irq_enable     = bus.wdata[NVA_IRQ_BIT_EN];
          nxt_mf_irq_enable     = bus.wdata[NVA_IRQ_BIT_MF_EN];
          nxt_global_irq_enable = bus.wdata[NVA_IRQ_BIT_GLOBAL];
          nxt_nv_irq_flag       = bus.wdata[NVA_IRQ_BIT_FLAG];
          nxt_mf_irq_flag       = bus.wdata[NVA_IRQ_BIT_MF_FLG];
        end
        default: ;
      endcase
    end else if (bus.op == NVA_OP_READ) begin
      nxt_rvalid = 1'b1;
      case (bus.sel)
        NVA_SEL_ADDR:  nxt_rdata = {1'b0, nv_address_reg_ff};
        NVA_SEL_DATA:  nxt_rdata = nv_data_reg_ff;
        NVA_SEL_PTR1L: nxt_rdata = pointer_one_low_ff;
        NVA_SEL_PTR1H: nxt_rdata = pointer_one_high_ff;
        NVA_SEL_PTR2L: nxt_rdata = pointer_two_low_ff;
        NVA_SEL_PTR2H: nxt_rdata = pointer_two_high_ff;
        NVA_SEL_IND1:  nxt_rdata = ctrl_sel ? {4'h0, ctrl_view} : 8'h00;
        NVA_SEL_IRQ:   nxt_rdata = {3'h0, mf_irq_flag_ff, nv_irq_flag_ff,
                                    global_irq_enable_ff, mf_irq_enable_ff, nv_irq_enable_ff};
        default:       nxt_rdata = 8'h00;
      endcase
    end

    // read cycle: data and start bit change together
    if (rd_start_ff) begin
      if (rd_cnt_ff == 2'h0) begin
        nxt_rd_start    = 1'b0;
        nxt_nv_data_reg = array_mem[nv_address_reg_ff];
      end else begin
        nxt_rd_cnt = rd_cnt_ff - 2'h1;
      end
    end

    // write completion: set wins over a software clear
    if (wr_done) begin
      nxt_wr_start    = 1'b0;
      nxt_nv_irq_flag = 1'b1;
      nxt_mf_irq_flag = 1'b1;
    end else if (bus.irq_ack && irq_ff) begin
      nxt_mf_irq_flag = 1'b0;
    end

    nxt_irq = nxt_nv_irq_flag && nxt_mf_irq_flag && nxt_nv_irq_enable
              && nxt_mf_irq_enable && nxt_global_irq_enable;
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      nv_address_reg_ff    <= '0;
      nv_data_reg_ff       <= 8'h00;
      pointer_one_low_ff   <= NVA_PTR_RESET;
      pointer_one_high_ff  <= NVA_PTR_RESET;
      pointer_two_low_ff   <= NVA_PTR_RESET;
      pointer_two_high_ff  <= NVA_PTR_RESET;
      write_permit_ff      <= NVA_CTRL_RESET[NVA_BIT_WR_PERMIT];
      read_permit_ff       <= NVA_CTRL_RESET[NVA_BIT_RD_PERMIT];
      wr_start_ff          <= NVA_CTRL_RESET[NVA_BIT_WR_START];
      rd_start_ff          <= NVA_CTRL_RESET[NVA_BIT_RD_START];
      nv_irq_enable_ff     <= 1'b0;
      mf_irq_enable_ff     <= 1'b0;
      global_irq_enable_ff <= 1'b0;
      nv_irq_flag_ff       <= 1'b0;
      mf_irq_flag_ff       <= 1'b0;
      rdata_ff             <= 8'h00;
      rvalid_ff            <= 1'b0;
      irq_ff               <= 1'b0;
      rd_cnt_ff            <= 2'h0;
    end else begin
      nv_address_reg_ff    <= nxt_nv_address_reg;
      nv_data_reg_ff       <= nxt_nv_data_reg;
      pointer_one_low_ff   <= nxt_pointer_one_low;
      pointer_one_high_ff  <= nxt_pointer_one_high;
      pointer_two_low_ff   <= nxt_pointer_two_low;
      pointer_two_high_ff  <= nxt_pointer_two_high;
      write_permit_ff      <= nxt_write_permit;
      read_permit_ff       <= nxt_read_permit;
      wr_start_ff          <= nxt_wr_start;
      rd_start_ff          <= nxt_rd_start;
      nv_irq_enable_ff     <= nxt_nv_irq_enable;
      mf_irq_enable_ff     <= nxt_mf_irq_enable;
      global_irq_enable_ff <= nxt_global_irq_enable;
      nv_irq_flag_ff       <= nxt_nv_irq_flag;
      mf_irq_flag_ff       <= nxt_mf_irq_flag;
      rdata_ff             <= nxt_rdata;
      rvalid_ff            <= nxt_rvalid;
      irq_ff               <= nxt_irq;
      rd_cnt_ff            <= nxt_rd_cnt;
    end
  end

  // array has no reset: contents are nonvolatile
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      array_mem[nv_address_reg_ff] <= nv_data_reg_ff;
    end
  end

  // ---------------------------------------------------------------
  // write timer, completion toggled and synchronised back
  // ---------------------------------------------------------------
  always_comb begin
    nxt_tmr_cnt      = tmr_cnt_ff;
    nxt_tmr_busy     = tmr_busy_ff;
    nxt_tmr_done_tgl = tmr_done_tgl_ff;
    if (mem_we) begin
      nxt_tmr_busy = 1'b1;
      nxt_tmr_cnt  = 16'(WRITE_CYCLES - 1);
    end else if (tmr_busy_ff) begin
      if (tmr_cnt_ff == 16'h0000) begin
        nxt_tmr_busy     = 1'b0;
        nxt_tmr_done_tgl = ~tmr_done_tgl_ff;
      end else begin
        nxt_tmr_cnt = tmr_cnt_ff - 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      tmr_cnt_ff      <= 16'h0000;
      tmr_busy_ff     <= 1'b0;
      tmr_done_tgl_ff <= 1'b0;
      done_sync1_ff   <= 1'b0;
      done_sync2_ff   <= 1'b0;
      done_seen_ff    <= 1'b0;
    end else begin
      tmr_cnt_ff      <= nxt_tmr_cnt;
      tmr_busy_ff     <= nxt_tmr_busy;
      tmr_done_tgl_ff <= nxt_tmr_done_tgl;
      done_sync1_ff   <= tmr_done_tgl_ff;
      done_sync2_ff   <= done_sync1_ff;
      done_seen_ff    <= done_sync2_ff;
    end
  end

  assign bus.rdata  = rdata_ff;
  assign bus.rvalid = rvalid_ff;
  assign bus.irq    = irq_ff;
endmodule

// >>> include/nva_pkg.sv
// package: constants and types for the nonvolatile data access block
package nva_pkg;
  // data memory sections and the control register location
  localparam logic [7:0] NVA_CTRL_LOW       = 8'h40;
  localparam logic [7:0] NVA_CTRL_HIGH      = 8'h01;
  localparam logic [7:0] NVA_PTR_RESET      = 8'h00;
  // control register bit positions
  localparam int         NVA_BIT_RD_START   = 0;
  localparam int         NVA_BIT_RD_PERMIT  = 1;
  localparam int         NVA_BIT_WR_START   = 2;
  localparam int         NVA_BIT_WR_PERMIT  = 3;
  localparam logic [3:0] NVA_CTRL_RESET     = 4'h0;
  // array size
  localparam int         NVA_ADDR_W         = 7;
  localparam int         NVA_DEPTH          = 128;
  // timing
  localparam int         NVA_CLK_MHZ        = 25;
  localparam int         NVA_WRITE_TIME_US  = 2;
  localparam int         NVA_WRITE_CYCLES   = NVA_WRITE_TIME_US * NVA_CLK_MHZ;
  localparam int         NVA_READ_CYCLES    = 2;

  // special function register bus operations
  typedef enum logic [2:0] {
    NVA_OP_NONE  = 3'b000,
    NVA_OP_WRITE = 3'b001,
    NVA_OP_READ  = 3'b010
  } nva_op_t;

  // register selectors on the core bus
  typedef enum logic [2:0] {
    NVA_SEL_ADDR  = 3'b000,
    NVA_SEL_DATA  = 3'b001,
    NVA_SEL_PTR1L = 3'b010,
    NVA_SEL_PTR1H = 3'b011,
    NVA_SEL_IND1  = 3'b100,
    NVA_SEL_IRQ   = 3'b101,
    NVA_SEL_PTR2L = 3'b110,
    NVA_SEL_PTR2H = 3'b111
  } nva_sel_t;

  // interrupt control register bit positions
  localparam int         NVA_IRQ_BIT_EN     = 0;
  localparam int         NVA_IRQ_BIT_MF_EN  = 1;
  localparam int         NVA_IRQ_BIT_GLOBAL = 2;
  localparam int         NVA_IRQ_BIT_FLAG   = 3;
  localparam int         NVA_IRQ_BIT_MF_FLG = 4;
endpackage

// >>> include/nva_if.sv
// interface: special function register bus between core and memory control
`timescale 1ns/1ps
interface nva_if;
  import nva_pkg::*;
  nva_op_t    op;
  nva_sel_t   sel;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rvalid;
  logic       irq;
  logic       irq_ack;

  modport device (
    input  op,
    input  sel,
    input  wdata,
    input  irq_ack,
    output rdata,
    output rvalid,
    output irq
  );
  modport core (
    output op,
    output sel,
    output wdata,
    output irq_ack,
    input  rdata,
    input  rvalid,
    input  irq
  );
endinterface

// >>> rtl/nva_core.sv
// core end: runs read and write sequences through the control register
`timescale 1ns/1ps
module nva_core (
  input  wire logic       core_clk,
  input  wire logic       rstn,
  input  wire logic       req_read,
  input  wire logic       req_write,
  input  wire logic [6:0] req_addr,
  input  wire logic [7:0] req_data,
  output logic            busy,
  output logic            done,
  output logic [7:0]      rd_data,
  nva_if.core             bus
);
  import nva_pkg::*;

  typedef enum logic [3:0] {
    NVC_IDLE    = 4'h0,
    NVC_GIE_OFF = 4'h1,
    NVC_ADDR    = 4'h2,
    NVC_DATA    = 4'h3,
    NVC_PTRL    = 4'h4,
    NVC_PTRH    = 4'h5,
    NVC_PERMIT  = 4'h6,
    NVC_START   = 4'h7,
    NVC_GIE_ON  = 4'h8,
    NVC_POLL    = 4'h9,
    NVC_WAIT    = 4'ha,
    NVC_CLR     = 4'hb,
    NVC_CLRH    = 4'hc,
    NVC_FETCH   = 4'hd,
    NVC_FWAIT   = 4'he
  } nvc_state_t;

  nvc_state_t state_ff, nxt_state;
  logic       is_wr_ff, nxt_is_wr;
  logic [6:0] addr_ff, nxt_addr;
  logic [7:0] data_ff, nxt_data;
  logic       busy_ff, nxt_busy;
  logic       done_ff, nxt_done;
  logic [7:0] rd_data_ff, nxt_rd_data;
  nva_op_t    op_ff, nxt_op;
  nva_sel_t   sel_ff, nxt_sel;
  logic [7:0] wdata_ff, nxt_wdata;
  logic [3:0] start_mask;

  assign start_mask = is_wr_ff ? 4'h4 : 4'h1;

  always_comb begin
    nxt_state   = state_ff;
    nxt_is_wr   = is_wr_ff;
    nxt_addr    = addr_ff;
    nxt_data    = data_ff;
    nxt_busy    = busy_ff;
    nxt_done    = 1'b0;
    nxt_rd_data = rd_data_ff;
    nxt_op      = NVA_OP_NONE;
    nxt_sel     = sel_ff;
    nxt_wdata   = wdata_ff;
    case (state_ff)
      NVC_IDLE: if (req_write || req_read) begin
        nxt_is_wr = req_write;
        nxt_addr  = req_addr;
        nxt_data  = req_data;
        nxt_busy  = 1'b1;
        nxt_state = req_write ? NVC_GIE_OFF : NVC_ADDR;
      end
      NVC_GIE_OFF: begin
        nxt_op = NVA_OP_WRITE; nxt_sel = NVA_SEL_IRQ; nxt_wdata = 8'h03;
        nxt_state = NVC_ADDR;
      end
      NVC_ADDR: begin
        nxt_op = NVA_OP_WRITE; nxt_sel = NVA_SEL_ADDR; nxt_wdata = {1'b0, addr_ff};
        nxt_state = is_wr_ff ? NVC_DATA : NVC_PTRL;
      end
      NVC_DATA: begin
        nxt_op = NVA_OP_WRITE; nxt_sel = NVA_SEL_DATA; nxt_wdata = data_ff;
        nxt_state = NVC_PTRL;
      end
      NVC_PTRL: begin
        nxt_op = NVA_OP_WRITE; nxt_sel = NVA_SEL_PTR1L; nxt_wdata = NVA_CTRL_LOW;
        nxt_state = NVC_PTRH;
      end
      NVC_PTRH: begin
        nxt_op = NVA_OP_WRITE; nxt_sel = NVA_SEL_PTR1H; nxt_wdata = NVA_CTRL_HIGH;
        nxt_state = NVC_PERMIT;
      end
      NVC_PERMIT: begin
        nxt_op = NVA_OP_WRITE; nxt_sel = NVA_SEL_IND1;
        nxt_wdata = is_wr_ff ? 8'h08 : 8'h02;
        nxt_state = NVC_START;
      end
      NVC_START: begin
        nxt_op = NVA_OP_WRITE; nxt_sel = NVA_SEL_IND1;
        nxt_wdata = is_wr_ff ? 8'h0c : 8'h03;
        nxt_state = is_wr_ff ? NVC_GIE_ON : NVC_POLL;
      end
      NVC_GIE_ON: begin
        nxt_op = NVA_OP_WRITE; nxt_sel = NVA_SEL_IRQ; nxt_wdata = 8'h07;
        nxt_state = NVC_POLL;
      end
      NVC_POLL: begin
        nxt_op = NVA_OP_READ; nxt_sel = NVA_SEL_IND1;
        nxt_state = NVC_WAIT;
      end
      NVC_WAIT: if (bus.rvalid) begin
        nxt_state = ((bus.rdata[3:0] & start_mask) != 4'h0) ? NVC_POLL : NVC_CLR;
      end
      NVC_CLR: begin
        nxt_op = NVA_OP_WRITE; nxt_sel = NVA_SEL_IND1; nxt_wdata = 8'h00;
        nxt_state = NVC_CLRH;
      end
      NVC_CLRH: begin
        nxt_op = NVA_OP_WRITE; nxt_sel = NVA_SEL_PTR1H; nxt_wdata = NVA_PTR_RESET;
        nxt_state = is_wr_ff ? NVC_IDLE : NVC_FETCH;
        if (is_wr_ff) begin
          nxt_busy = 1'b0;
          nxt_done = 1'b1;
        end
      end
      NVC_FETCH: begin
        nxt_op = NVA_OP_READ; nxt_sel = NVA_SEL_DATA;
        nxt_state = NVC_FWAIT;
      end
      NVC_FWAIT: if (bus.rvalid) begin
        nxt_rd_data = bus.rdata;
        nxt_busy = 1'b0;
        nxt_done = 1'b1;
        nxt_state = NVC_IDLE;
      end
      default: nxt_state = NVC_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_ff   <= NVC_IDLE;
      is_wr_ff   <= 1'b0;
      addr_ff    <= 7'h00;
      data_ff    <= 8'h00;
      busy_ff    <= 1'b0;
      done_ff    <= 1'b0;
      rd_data_ff <= 8'h00;
      op_ff      <= NVA_OP_NONE;
      sel_ff     <= NVA_SEL_ADDR;
      wdata_ff   <= 8'h00;
    end else begin
      state_ff   <= nxt_state;
      is_wr_ff   <= nxt_is_wr;
      addr_ff    <= nxt_addr;
      data_ff    <= nxt_data;
      busy_ff    <= nxt_busy;
      done_ff    <= nxt_done;
      rd_data_ff <= nxt_rd_data;
      op_ff      <= nxt_op;
      sel_ff     <= nxt_sel;
      wdata_ff   <= nxt_wdata;
    end
  end

  assign busy        = busy_ff;
  assign done        = done_ff;
  assign rd_data     = rd_data_ff;
  assign bus.op      = op_ff;
  assign bus.sel     = sel_ff;
  assign bus.wdata   = wdata_ff;
  assign bus.irq_ack = 1'b0;
endmodule

// >>> verif/nva_sva.sv
// checker: bus and interrupt relations between the core end and the device end
`timescale 1ns/1ps
module nva_sva #(
  parameter int WRITE_CYCLES = nva_pkg::NVA_WRITE_CYCLES
) (
  input wire logic              core_clk,
  input wire logic              rstn,
  input wire nva_pkg::nva_op_t  op,
  input wire nva_pkg::nva_sel_t sel,
  input wire logic [7:0]        wdata,
  input wire logic [7:0]        rdata,
  input wire logic              rvalid,
  input wire logic              irq,
  input wire logic              irq_ack
);
  import nva_pkg::*;
  localparam int WR_LIM = WRITE_CYCLES + 12;
  logic [2:0] en_ff;
  logic [2:0] nxt_en;
  logic [7:0] p1l_ff;
  logic [7:0] nxt_p1l;
  logic [7:0] p1h_ff;
  logic [7:0] nxt_p1h;
  logic       rd_ctrl_ff;
  logic       nxt_rd_ctrl;
  logic       wr_ind;
  logic       wr_reg;

  // ---------------------------------------------
  // shadow of what the core end has written
  // ---------------------------------------------
  always_comb begin
    wr_reg      = (op == NVA_OP_WRITE);
    wr_ind      = wr_reg && (sel == NVA_SEL_IND1);
    nxt_en      = (wr_reg && sel == NVA_SEL_IRQ) ? wdata[2:0] : en_ff;
    nxt_p1l     = (wr_reg && sel == NVA_SEL_PTR1L) ? wdata : p1l_ff;
    nxt_p1h     = (wr_reg && sel == NVA_SEL_PTR1H) ? wdata : p1h_ff;
    nxt_rd_ctrl = (op == NVA_OP_READ) && (sel == NVA_SEL_IND1);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      en_ff      <= 3'h0;
      p1l_ff     <= 8'h00;
      p1h_ff     <= 8'h00;
      rd_ctrl_ff <= 1'b0;
    end else begin
      en_ff      <= nxt_en;
      p1l_ff     <= nxt_p1l;
      p1h_ff     <= nxt_p1h;
      rd_ctrl_ff <= nxt_rd_ctrl;
    end
  end

  // ---------------------------------------------
  // assertions
  // ---------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  AST_READ_ANSWER: assert property (op == NVA_OP_READ |=> rvalid)
    else $error("read got no answer");
  AST_NO_STRAY_ANSWER: assert property (op != NVA_OP_READ |=> !rvalid)
    else $error("answer without a read");
  AST_RDATA_HOLDS: assert property (!rvalid |-> $stable(rdata))
    else $error("read data moved without a read");
  AST_IRQ_ENABLES: assert property (irq |-> &en_ff)
    else $error("interrupt with an enable off");
  AST_IRQ_AT_END: assert property (wr_ind && wdata == 8'h0c |-> ##[1:WR_LIM] irq)
    else $error("no interrupt after write cycle");
  AST_QUIET_MIDWRITE: assert property (rd_ctrl_ff && rdata[2] |-> !$past(irq, 2))
    else $error("interrupt while write cycle runs");
  AST_START_FOLLOWS_PERMIT: assert property (wr_ind && wdata == 8'h08 |=> wr_ind && wdata == 8'h0c)
    else $error("write start not next after permit");
  AST_GLOBAL_OFF_AT_START: assert property (wr_ind && wdata[2] |-> !en_ff[2])
    else $error("global enable on at write start");
  AST_GLOBAL_BACK: assert property (wr_ind && wdata == 8'h0c |=> wr_reg && sel == NVA_SEL_IRQ && wdata[2])
    else $error("global enable not restored after start");
  AST_POINTER_SET: assert property (wr_ind |-> p1l_ff == NVA_CTRL_LOW && p1h_ff == NVA_CTRL_HIGH)
    else $error("control written with wrong pointer");
  AST_PERMIT_DROPPED: assert property (wr_ind && wdata == 8'h00 |=> wr_reg && sel == NVA_SEL_PTR1H && wdata == NVA_PTR_RESET)
    else $error("pointer high not cleared after permit drop");
  AST_READ_PERMIT_FIRST: assert property (wr_ind && wdata == 8'h03 |-> $past(wr_ind) && $past(wdata) == 8'h02)
    else $error("read start without permit first");
  AST_IRQ_STAYS: assert property (irq && !irq_ack && !(wr_reg && sel == NVA_SEL_IRQ) |=> irq)
    else $error("interrupt dropped without service");

  COV_WRITE_START: cover property (wr_ind && wdata == 8'h0c);
  COV_READ_START: cover property (wr_ind && wdata == 8'h03);
  COV_IRQ_RISE: cover property ($rose(irq));
endmodule

// >>> verif/tb_eeprom_data_access_control.sv
// testbench: core end against device end, plus a bench-driven device end
`timescale 1ns/1ps
module tb_eeprom_data_access_control;
  import nva_pkg::*;
  localparam int WC = 4;
  logic       core_clk;
  logic       rstn;
  logic       req_read;
  logic       req_write;
  logic       busy;
  logic       done;
  logic [6:0] req_addr;
  logic [7:0] req_data;
  logic [7:0] rd_data;
  int         failures;
  int         comparisons;
  nva_sel_t   ptrs [4] = '{NVA_SEL_PTR1L, NVA_SEL_PTR1H, NVA_SEL_PTR2L, NVA_SEL_PTR2H};
  logic [6:0] addrs [3] = '{7'h00, 7'h7f, 7'h2a};
  logic [7:0] datas [3] = '{8'ha5, 8'h3c, 8'hff};

  nva_if link_a ();
  nva_if link_b ();
  nva_device #(.WRITE_CYCLES(WC)) u_nva_device (.core_clk(core_clk), .rstn(rstn), .bus(link_a));
  nva_device #(.WRITE_CYCLES(WC)) u_nva_device_b (.core_clk(core_clk), .rstn(rstn), .bus(link_b));
  nva_core u_nva_core (.core_clk(core_clk), .rstn(rstn), .req_read(req_read),
    .req_write(req_write), .req_addr(req_addr), .req_data(req_data), .busy(busy),
    .done(done), .rd_data(rd_data), .bus(link_a));
  nva_sva #(.WRITE_CYCLES(WC)) u_nva_sva (.core_clk(core_clk), .rstn(rstn), .op(link_a.op),
    .sel(link_a.sel), .wdata(link_a.wdata), .rdata(link_a.rdata), .rvalid(link_a.rvalid),
    .irq(link_a.irq), .irq_ack(link_a.irq_ack));

  // ---------------------------------------------
  // compare, report and bus tasks
  // ---------------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic stuck(input string what);
    failures++;
    $display("BAD %s expected finish seen timeout", what);
    results();
  endtask

  task automatic bw(input nva_sel_t s, input logic [7:0] d);
    @(negedge core_clk);
    link_b.op    = NVA_OP_WRITE;
    link_b.sel   = s;
    link_b.wdata = d;
    @(negedge core_clk);
    link_b.op = NVA_OP_NONE;
  endtask

  task automatic br(input nva_sel_t s, output logic [7:0] d);
    @(negedge core_clk);
    link_b.op  = NVA_OP_READ;
    link_b.sel = s;
    @(negedge core_clk);
    link_b.op = NVA_OP_NONE;
    check("answer strobe", 8'h01, {7'h0, link_b.rvalid});
    d = link_b.rdata;
  endtask

  task automatic bc(input nva_sel_t s, input logic [7:0] exp, input string what);
    logic [7:0] d;
    br(s, d);
    check(what, exp, d);
  endtask

  task automatic poll_b(input int bitn);
    logic [7:0] d;
    d = 8'hff;
    for (int i = 0; i < 40 && d[bitn] !== 1'b0; i++) br(NVA_SEL_IND1, d);
    if (d[bitn] !== 1'b0) stuck("control poll");
  endtask

  task automatic core_req(input logic wr, input logic [6:0] a, input logic [7:0] d,
                          input logic [7:0] exp);
    int n;
    @(negedge core_clk);
    req_write = wr;
    req_read  = !wr;
    req_addr  = a;
    req_data  = d;
    @(negedge core_clk);
    req_write = 1'b0;
    req_read  = 1'b0;
    check("core busy", 8'h01, {7'h0, busy});
    n = 0;
    while (done !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    if (done !== 1'b1) stuck("core done");
    check("core idle", 8'h00, {7'h0, busy});
    if (!wr) check("core read byte", exp, rd_data);
  endtask

  // ---------------------------------------------
  // clock and main sequence
  // ---------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  initial begin
    failures       = 0;
    comparisons    = 0;
    rstn           = 1'b0;
    req_read       = 1'b0;
    req_write      = 1'b0;
    req_addr       = 7'h00;
    req_data       = 8'h00;
    link_b.op      = NVA_OP_NONE;
    link_b.sel     = NVA_SEL_ADDR;
    link_b.wdata   = 8'h00;
    link_b.irq_ack = 1'b0;
    repeat (3) @(negedge core_clk);
    rstn = 1'b1;
    foreach (ptrs[i]) bc(ptrs[i], NVA_PTR_RESET, "pointer at power-on");
    bc(NVA_SEL_IND1, 8'h00, "control through section 0");
    bw(NVA_SEL_PTR1L, NVA_CTRL_LOW);
    bw(NVA_SEL_PTR1H, NVA_CTRL_HIGH);
    bc(NVA_SEL_IND1, {4'h0, NVA_CTRL_RESET}, "control at power-on");
    bc(NVA_SEL_IRQ, 8'h00, "irq control at power-on");
    bw(NVA_SEL_ADDR, 8'hff);
    bc(NVA_SEL_ADDR, 8'h7f, "address top bit");
    $display("test power-on done");
    bw(NVA_SEL_IND1, 8'h04);
    bc(NVA_SEL_IND1, 8'h00, "write start without permit");
    bw(NVA_SEL_IND1, 8'h01);
    bc(NVA_SEL_IND1, 8'h00, "read start without permit");
    bw(NVA_SEL_IND1, 8'h0c);
    bc(NVA_SEL_IND1, 8'h08, "permit and start together");
    bw(NVA_SEL_PTR1H, NVA_PTR_RESET);
    bw(NVA_SEL_IND1, 8'h00);
    bc(NVA_SEL_IND1, 8'h00, "control hidden");
    bw(NVA_SEL_PTR1H, NVA_CTRL_HIGH);
    $display("test refusals done");
    bw(NVA_SEL_ADDR, 8'h05);
    bw(NVA_SEL_DATA, 8'h5a);
    bw(NVA_SEL_IRQ, 8'h03);
    bw(NVA_SEL_IND1, 8'h0c);
    bc(NVA_SEL_IND1, 8'h0c, "write cycle running");
    bc(NVA_SEL_IRQ, 8'h03, "no flag mid-write");
    poll_b(NVA_BIT_WR_START);
    bc(NVA_SEL_IRQ, 8'h1b, "both flags set");
    check("irq with global off", 8'h00, {7'h0, link_b.irq});
    bw(NVA_SEL_IRQ, 8'h1f);
    check("irq all enabled", 8'h01, {7'h0, link_b.irq});
    bw(NVA_SEL_IRQ, 8'h1e);
    check("irq own enable off", 8'h00, {7'h0, link_b.irq});
    bw(NVA_SEL_IRQ, 8'h1d);
    check("irq group enable off", 8'h00, {7'h0, link_b.irq});
    bw(NVA_SEL_IRQ, 8'h1f);
    @(negedge core_clk);
    link_b.irq_ack = 1'b1;
    @(negedge core_clk);
    link_b.irq_ack = 1'b0;
    check("irq after service", 8'h00, {7'h0, link_b.irq});
    bc(NVA_SEL_IRQ, 8'h0f, "flags after service");
    bw(NVA_SEL_IRQ, 8'h07);
    bc(NVA_SEL_IRQ, 8'h07, "flag cleared by software");
    $display("test write and interrupt done");
    bw(NVA_SEL_DATA, 8'h00);
    bw(NVA_SEL_IND1, 8'h0a);
    bw(NVA_SEL_IND1, 8'h0b);
    poll_b(NVA_BIT_RD_START);
    bc(NVA_SEL_DATA, 8'h5a, "fetched byte");
    bc(NVA_SEL_DATA, 8'h5a, "byte held");
    bc(NVA_SEL_IRQ, 8'h07, "no request from read");
    $display("test read done");
    foreach (addrs[i]) core_req(1'b1, addrs[i], datas[i], 8'h00);
    foreach (addrs[i]) core_req(1'b0, addrs[i], 8'h00, datas[i]);
    $display("test core end done");
    results();
  end
endmodule
